// ==== rtc_control_irq_enable_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module rtc_control_irq_enable_test;
    import rtcc_pkg::*;

    // Long enough that the in-progress state can be read back
    localparam int SLEN = 8;

    logic        mclk;
    logic        arst_n;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    wire logic   hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        overflowEvt;
    logic        cmpEvt;
    logic        counterEnable;
    logic [1:0]  modeSel;
    logic        hourFmt12;
    logic        irq;
    logic [31:0] rd;
    logic [4:0]  snap;
    int          nFail;
    int          cmpCount;

    // Single slave: its ready is the bus ready
    assign hready = hreadyout;

    rtcc_ctrl #(.SYNC_LEN(SLEN)) rtcc_ctrl_i (
        .mclk          (mclk),
        .arst_n        (arst_n),
        .hsel          (hsel),
        .haddr         (haddr),
        .htrans        (htrans),
        .hwrite        (hwrite),
        .hsize         (hsize),
        .hwdata        (hwdata),
        .hready        (hready),
        .hrdata        (hrdata),
        .hreadyout     (hreadyout),
        .hresp         (hresp),
        .overflowEvt   (overflowEvt),
        .cmpEvt        (cmpEvt),
        .counterEnable (counterEnable),
        .modeSel       (modeSel),
        .hourFmt12     (hourFmt12),
        .irq           (irq)
    );

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // Pins sampled mid-cycle so checks never race the clock edge
    always @(negedge mclk) begin
        snap <= {irq, counterEnable, hourFmt12, modeSel};
    end

    // ****************************************
    // Bus tasks and checks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        cmpCount++;
        if (got !== exp) begin
            nFail++;
            $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // Returns just after the edge at which hready is seen high
    task automatic waitRdy(output logic [31:0] d);
        @(negedge mclk);
        while (hreadyout !== 1'b1) @(negedge mclk);
        d = hrdata;
        @(posedge mclk);
    endtask

    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                        output logic [31:0] d);
        logic [31:0] tmp;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsel <= 1'b1;
        waitRdy(tmp);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        waitRdy(d);
        chk({31'h0, hresp}, 32'h0, "response");
    endtask

    task automatic wr(input logic [3:0] idx, input logic [31:0] wd);
        xfer(1'b1, {26'h0, idx, 2'h0}, wd, rd);
    endtask

    task automatic rdc(input logic [3:0] idx, input logic [31:0] exp, input string msg);
        xfer(1'b0, {26'h0, idx, 2'h0}, 32'h0, rd);
        chk(rd, exp, msg);
    endtask

    task automatic pins(input logic [4:0] exp, input string msg);
        repeat (3) @(posedge mclk);
        chk({27'h0, snap}, {27'h0, exp}, msg);
    endtask

    task automatic pulse(input logic o, input logic c);
        overflowEvt <= o;
        cmpEvt <= c;
        @(posedge mclk);
        overflowEvt <= 1'b0;
        cmpEvt <= 1'b0;
    endtask

    task automatic waitSync;
        int n;
        n = 0;
        do begin
            xfer(1'b0, {26'h0, IDX_STATUS, 2'h0}, 32'h0, rd);
            n++;
        end while (rd[STATUS_PEND_BIT] !== 1'b0 && n < 20);
        chk(rd, 32'h0, "pending never cleared");
    endtask

    task automatic closeOut;
        $display("comparisons %0d mismatches %0d", cmpCount, nFail);
        if (nFail == 0 && cmpCount > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #(40 * 4000);
        nFail++;
        closeOut();
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        nFail = 0;
        cmpCount = 0;
        arst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        overflowEvt = 1'b0;
        cmpEvt = 1'b0;
        repeat (8) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        rdc(IDX_CTRL, {16'h0, CTRL_RST}, "ctrl reset");
        rdc(IDX_IEN_SET, {24'h0, IEN_RST}, "enable reset");
        rdc(IDX_STATUS, 32'h0, "status reset");
        wr(IDX_IEN_SET, 32'hff);
        rdc(IDX_IEN_SET, {24'h0, IRQ_MASK}, "set all");
        rdc(IDX_IEN_CLR, {24'h0, IRQ_MASK}, "shared view");
        wr(IDX_IEN_SET, 32'h0);
        wr(IDX_IEN_CLR, 32'h0);
        rdc(IDX_IEN_CLR, {24'h0, IRQ_MASK}, "zero writes");
        wr(IDX_IEN_CLR, 32'h40);
        rdc(IDX_IEN_SET, 32'h81, "clear sync");
        wr(IDX_IEN_CLR, 32'h01);
        rdc(IDX_IEN_SET, 32'h80, "clear alarm");
        // Events against enables
        pulse(1'b1, 1'b0);
        pins(5'h10, "overflow irq");
        rdc(IDX_FLAG, 32'h80, "overflow flag");
        wr(IDX_IEN_CLR, 32'h80);
        pins(5'h00, "masked irq");
        pulse(1'b0, 1'b1);
        pins(5'h00, "alarm masked");
        wr(IDX_IEN_SET, 32'h01);
        pins(5'h10, "alarm irq");
        wr(IDX_FLAG, 32'hff);
        rdc(IDX_FLAG, 32'h0, "flags cleared");
        pins(5'h00, "irq dropped");
        // Modes, unsynchronized
        for (int m = 0; m < 3; m++) begin
            wr(IDX_CTRL, 32'(m) << CTRL_MODE_LSB);
            pins({3'h0, 2'(m)}, "mode pins");
            rdc(IDX_STATUS, 32'h0, "mode no pending");
        end
        wr(IDX_CTRL, 32'h0c);
        pins(5'h02, "reserved mode");
        wr(IDX_CTRL, 32'h48);
        pins(5'h06, "12 hour calendar");
        wr(IDX_CTRL, 32'h44);
        pins(5'h01, "hour bit outside calendar");
        rdc(IDX_CTRL, 32'h44, "hour bit stored");
        // Synchronized enable
        wr(IDX_IEN_SET, 32'h40);
        wr(IDX_CTRL, 32'h0a);
        rdc(IDX_STATUS, 32'h80, "enable pending");
        chk({31'h0, snap[3]}, 32'h0, "enable not yet effective");
        rdc(IDX_CTRL, 32'h0a, "enable readback");
        waitSync();
        pins(5'h1a, "enabled with sync irq");
        rdc(IDX_FLAG, 32'h40, "sync flag");
        wr(IDX_CTRL, 32'h4a);
        rdc(IDX_CTRL, 32'h0a, "hour locked");
        pins(5'h1a, "hour pin locked");
        // Soft reset with other fields in the same write
        wr(IDX_FLAG, 32'hff);
        wr(IDX_IEN_SET, 32'hc1);
        wr(IDX_CTRL, 32'h4f);
        rdc(IDX_STATUS, 32'h80, "reset pending");
        rdc(IDX_CTRL, 32'h09, "reset in progress");
        chk({31'h0, snap[3]}, 32'h1, "still running while disabling");
        waitSync();
        rdc(IDX_CTRL, 32'h0, "reset done");
        rdc(IDX_IEN_SET, 32'h0, "enables reset");
        rdc(IDX_FLAG, 32'h0, "flags reset");
        pins(5'h00, "disabled");
        // Unmapped and misaligned places
        xfer(1'b1, 32'h40, 32'hff, rd);
        xfer(1'b1, 32'h1d, 32'hff, rd);
        rdc(IDX_IEN_SET, 32'h0, "stray writes");
        xfer(1'b0, 32'h40, 32'h0, rd);
        chk(rd, 32'h0, "unmapped read");
        closeOut();
    end
endmodule
`default_nettype wire

// ==== rtcc_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none
module rtcc_ctrl
    import rtcc_pkg::*;
#(
    parameter int SYNC_LEN = SYNC_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        arst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        overflowEvt,
    input  wire logic        cmpEvt,
    output logic             counterEnable,
    output logic      [1:0]  modeSel,
    output logic             hourFmt12,
    output logic             irq
);

    // ****************************************
    // Reset release
    // ****************************************
    logic [1:0] rstPipe_ff;
    logic       rstSync_n;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rstPipe_ff <= 2'h0;
        end else begin
            rstPipe_ff <= {rstPipe_ff[0], 1'b1};
        end
    end

    assign rstSync_n = rstPipe_ff[1];

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic        dpAct;
        logic        dpWr;
        logic [3:0]  dpIdx;
        logic        dpOk;
        logic        ready;
        logic        resp;
        logic [31:0] rdata;
        logic        ctrlEn;
        logic        softRst;
        rtcc_mode_t  mode;
        logic        hourFmt;
        logic        runEn;
        logic        hour12;
        logic [7:0]  ien;
        logic [7:0]  flags;
        logic        irq;
    } rtcc_ctrl_st_t;

    rtcc_ctrl_st_t st_ff;
    rtcc_ctrl_st_t nxt_st;

    rtcc_sync_if sif ();

    rtcc_sync_delay #(
        .SYNC_LEN (SYNC_LEN)
    ) rtcc_sync_delay_i (
        .mclk  (mclk),
        .rst_n (rstSync_n),
        .sif   (sif)
    );

    logic       accept;
    logic       wrAny;
    logic       wrCtrl;
    logic       wrClr;
    logic       wrSet;
    logic       wrFlag;
    logic       syncReq;
    logic       swDone;
    logic [7:0] wrByte;
    logic [7:0] evt;

    assign accept = hsel && htrans[1] && hready;
    assign wrAny  = st_ff.dpAct && st_ff.dpWr && st_ff.dpOk;
    assign wrCtrl = wrAny && (st_ff.dpIdx == IDX_CTRL);
    assign wrClr  = wrAny && (st_ff.dpIdx == IDX_IEN_CLR);
    assign wrSet  = wrAny && (st_ff.dpIdx == IDX_IEN_SET);
    assign wrFlag = wrAny && (st_ff.dpIdx == IDX_FLAG);
    assign wrByte = hwdata[7:0] & IRQ_MASK;
    assign swDone = sif.done && st_ff.softRst;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        nxt_st  = st_ff;
        syncReq = 1'b0;
        evt     = 8'h00;

        // Bus data phase: one wait cycle, then the answer
        if (st_ff.dpAct) begin
            nxt_st.dpAct = 1'b0;
            nxt_st.ready = 1'b1;
            nxt_st.rdata = 32'h0;
            if (!st_ff.dpWr && st_ff.dpOk) begin
                case (st_ff.dpIdx)
                    IDX_CTRL: begin
                        nxt_st.rdata[CTRL_SOFTRST_BIT] = st_ff.softRst;
                        nxt_st.rdata[CTRL_EN_BIT] = st_ff.ctrlEn;
                        nxt_st.rdata[CTRL_MODE_LSB +: 2] = st_ff.mode;
                        nxt_st.rdata[CTRL_HOUR_BIT] = st_ff.hourFmt;
                    end
                    IDX_IEN_CLR, IDX_IEN_SET: begin
                        nxt_st.rdata[7:0] = st_ff.ien;
                    end
                    IDX_FLAG: begin
                        nxt_st.rdata[7:0] = st_ff.flags;
                    end
                    IDX_STATUS: begin
                        nxt_st.rdata[STATUS_PEND_BIT] = sif.busy;
                    end
                    default: begin
                        nxt_st.rdata = 32'h0;
                    end
                endcase
            end
        end
        if (accept) begin
            nxt_st.dpAct = 1'b1;
            nxt_st.dpWr  = hwrite;
            nxt_st.dpIdx = rtccRegIdx(haddr);
            nxt_st.dpOk  = rtccMapped(haddr);
            nxt_st.ready = 1'b0;
        end

        // Control register
        if (wrCtrl) begin
            if (hwdata[CTRL_SOFTRST_BIT]) begin
                // Reset wins; the rest of this write is thrown away
                nxt_st.softRst = 1'b1;
                nxt_st.ctrlEn  = 1'b0;
                syncReq        = 1'b1;
            end else if (!st_ff.softRst) begin
                // Mode is taken directly, no sync round trip
                if (hwdata[CTRL_MODE_LSB +: 2] != 2'(MODE_RSVD)) begin
                    nxt_st.mode = rtcc_mode_t'(hwdata[CTRL_MODE_LSB +: 2]);
                end
                if (!st_ff.ctrlEn && !st_ff.runEn) begin
                    nxt_st.hourFmt = hwdata[CTRL_HOUR_BIT];
                end
                if (hwdata[CTRL_EN_BIT] != st_ff.ctrlEn) begin
                    nxt_st.ctrlEn = hwdata[CTRL_EN_BIT];
                    syncReq       = 1'b1;
                end
            end
        end

        // Shared enable bits behind the set and clear views
        if (wrClr) begin
            nxt_st.ien = st_ff.ien & ~wrByte;
        end
        if (wrSet) begin
            nxt_st.ien = st_ff.ien | wrByte;
        end

        // Events; a set in the clearing cycle still lands
        evt[IRQ_OVERFLOW_BIT] = overflowEvt;
        evt[IRQ_CMP_BIT]      = cmpEvt;
        evt[IRQ_SYNC_BIT]     = sif.done && !st_ff.softRst;
        if (wrFlag) begin
            nxt_st.flags = st_ff.flags & ~wrByte;
        end
        nxt_st.flags = nxt_st.flags | (evt & IRQ_MASK);

        // Enable change reaches the counter side
        if (sif.done && !st_ff.softRst) begin
            nxt_st.runEn = st_ff.ctrlEn;
        end

        // Soft reset completion overrides all register writes and events from this cycle except a new soft reset
        if (swDone) begin
            // A soft reset written in this very cycle starts over
            nxt_st.softRst = syncReq;
            nxt_st.ctrlEn  = CTRL_RST[CTRL_EN_BIT];
            nxt_st.mode    = rtcc_mode_t'(CTRL_RST[CTRL_MODE_LSB +: 2]);
            nxt_st.hourFmt = CTRL_RST[CTRL_HOUR_BIT];
            nxt_st.runEn   = 1'b0;
            nxt_st.ien     = IEN_RST;
            nxt_st.flags   = FLAG_RST;
        end

        nxt_st.hour12 = nxt_st.hourFmt && (nxt_st.mode == MODE_CAL);
        nxt_st.irq    = |(nxt_st.flags & nxt_st.ien);
        nxt_st.resp   = 1'b0;
    end

    assign sif.req = syncReq;

    always_ff @(posedge mclk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            st_ff       <= '0;
            st_ff.ready <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign hrdata        = st_ff.rdata;
    assign hreadyout     = st_ff.ready;
    assign hresp         = st_ff.resp;
    assign counterEnable = st_ff.runEn;
    assign modeSel       = st_ff.mode;
    assign hourFmt12     = st_ff.hour12;
    assign irq           = st_ff.irq;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstSync_n);

    hour_gate_a: assert property (
        hourFmt12 |-> (modeSel == 2'(MODE_CAL)) && st_ff.hourFmt
    ) else $error("hour format active outside calendar mode");

    hour_lock_a: assert property (
        (st_ff.ctrlEn || st_ff.runEn) && !swDone |=> $stable(st_ff.hourFmt)
    ) else $error("hour format changed while enabled");

    mode_legal_a: assert property (
        modeSel != 2'(MODE_RSVD)
    ) else $error("reserved mode reached");

    en_readback_a: assert property (
        wrCtrl && !hwdata[CTRL_SOFTRST_BIT] && !st_ff.softRst
            && (hwdata[CTRL_EN_BIT] != st_ff.ctrlEn) && !swDone
        |=> sif.busy && (st_ff.ctrlEn == $past(hwdata[CTRL_EN_BIT]))
    ) else $error("enable write did not read back or raise pending");

    en_settle_a: assert property (
        $rose(st_ff.ctrlEn) && !st_ff.softRst |-> ##[1:40] (counterEnable || !st_ff.ctrlEn)
    ) else $error("enable never took effect");

    soft_drop_a: assert property (
        wrCtrl && hwdata[CTRL_SOFTRST_BIT] && !swDone
        |=> st_ff.softRst && !st_ff.ctrlEn && (st_ff.mode == $past(st_ff.mode))
    ) else $error("soft reset write leaked other fields");

    soft_pend_a: assert property (
        st_ff.softRst |-> sif.busy
    ) else $error("soft reset without pending");

    soft_end_a: assert property (
        $fell(st_ff.softRst) |-> $fell(sif.busy) && (st_ff.ien == IEN_RST) && !counterEnable
    ) else $error("soft reset finished out of step");

    soft_hold_a: assert property (
        st_ff.softRst && !swDone |=> st_ff.softRst
    ) else $error("soft reset dropped before its end");

    soft_done_a: assert property (
        swDone |=> !st_ff.ctrlEn && !counterEnable && (st_ff.ien == IEN_RST)
            && (st_ff.flags == FLAG_RST) && (modeSel == CTRL_RST[CTRL_MODE_LSB +: 2])
            && (st_ff.hourFmt == CTRL_RST[CTRL_HOUR_BIT])
    ) else $error("soft reset left state behind");

    mode_take_a: assert property (
        wrCtrl && !hwdata[CTRL_SOFTRST_BIT] && !st_ff.softRst && !swDone
            && (hwdata[CTRL_MODE_LSB +: 2] != 2'(MODE_RSVD))
        |=> modeSel == $past(hwdata[CTRL_MODE_LSB +: 2])
    ) else $error("mode write not taken");

    mode_rsvd_a: assert property (
        wrCtrl && (hwdata[CTRL_MODE_LSB +: 2] == 2'(MODE_RSVD)) && !swDone
        |=> $stable(modeSel)
    ) else $error("reserved mode value taken");

    hour_take_a: assert property (
        wrCtrl && !hwdata[CTRL_SOFTRST_BIT] && !st_ff.softRst && !swDone
            && !st_ff.ctrlEn && !st_ff.runEn
        |=> st_ff.hourFmt == $past(hwdata[CTRL_HOUR_BIT])
    ) else $error("hour format write lost while disabled");

    ien_clr_a: assert property (
        wrClr && hwdata[IRQ_SYNC_BIT] |=> !st_ff.ien[IRQ_SYNC_BIT]
    ) else $error("sync enable not cleared");

    alarm_clr_a: assert property (
        wrClr && hwdata[IRQ_CMP_BIT] |=> !st_ff.ien[IRQ_CMP_BIT]
    ) else $error("alarm enable not cleared");

    irq_level_a: assert property (
        $past(overflowEvt) && st_ff.ien[IRQ_OVERFLOW_BIT] |-> irq
    ) else $error("enabled event gave no interrupt");

    ien_set_a: assert property (
        wrSet && hwdata[IRQ_SYNC_BIT] && !swDone |=> st_ff.ien[IRQ_SYNC_BIT]
    ) else $error("sync enable not set");

    mode_nosync_a: assert property (
        wrCtrl && !sif.busy && !hwdata[CTRL_SOFTRST_BIT]
            && (hwdata[CTRL_EN_BIT] == st_ff.ctrlEn) |=> !sif.busy
    ) else $error("mode write raised pending");

    overflow_set_a: assert property (
        wrSet && hwdata[IRQ_OVERFLOW_BIT] && !swDone |=> st_ff.ien[IRQ_OVERFLOW_BIT]
    ) else $error("overflow enable not set");

    sync_keep_a: assert property (
        wrSet && !hwdata[IRQ_SYNC_BIT] && !swDone |=> $stable(st_ff.ien[IRQ_SYNC_BIT])
    ) else $error("zero write changed sync enable");

    alarm_keep_a: assert property (
        wrClr && !hwdata[IRQ_CMP_BIT] && !swDone |=> $stable(st_ff.ien[IRQ_CMP_BIT])
    ) else $error("zero write changed alarm enable");

    sync_irq_a: assert property (
        $past(sif.done && !st_ff.softRst) && st_ff.ien[IRQ_SYNC_BIT] |-> irq
    ) else $error("sync done gave no interrupt");

    alarm_irq_a: assert property (
        $past(cmpEvt) && st_ff.ien[IRQ_CMP_BIT] |-> irq
    ) else $error("alarm event gave no interrupt");

endmodule
`default_nettype wire

// ==== rtcc_pkg.sv ====
`default_nettype none
package rtcc_pkg;

    // ****************************************
    // Register indices (byte address = 4 x index)
    // ****************************************
    localparam logic [3:0] IDX_CTRL    = 4'h0;
    localparam logic [3:0] IDX_IEN_CLR = 4'h6;
    localparam logic [3:0] IDX_IEN_SET = 4'h7;
    localparam logic [3:0] IDX_FLAG    = 4'h8;
    localparam logic [3:0] IDX_STATUS  = 4'ha;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTRL_SOFTRST_BIT = 0;
    localparam int CTRL_EN_BIT      = 1;
    localparam int CTRL_MODE_LSB    = 2;
    localparam int CTRL_HOUR_BIT    = 6;
    localparam int IRQ_CMP_BIT      = 0;
    localparam int IRQ_SYNC_BIT     = 6;
    localparam int IRQ_OVERFLOW_BIT = 7;
    localparam int STATUS_PEND_BIT  = 7;

    // ****************************************
    // Reset values and masks
    // ****************************************
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [7:0]  IEN_RST  = 8'h00;
    localparam logic [7:0]  FLAG_RST = 8'h00;
    localparam logic [7:0]  IRQ_MASK = 8'hc1;

    // ****************************************
    // Timing
    // ****************************************
    localparam int SYNC_CYCLES = 4;

    typedef enum logic [1:0] {
        MODE_WIDE,
        MODE_NARROW,
        MODE_CAL,
        MODE_RSVD
    } rtcc_mode_t;

    function automatic logic [3:0] rtccRegIdx(input logic [31:0] addr);
        return addr[5:2];
    endfunction

    function automatic logic rtccMapped(input logic [31:0] addr);
        return (addr[31:6] == 26'h0) && (addr[1:0] == 2'h0);
    endfunction

endpackage
`default_nettype wire

// ==== rtcc_sync_delay.sv ====
`timescale 1ns/100ps
`default_nettype none
module rtcc_sync_delay
    import rtcc_pkg::*;
#(
    parameter int SYNC_LEN = SYNC_CYCLES
) (
    input wire logic    mclk,
    input wire logic    rst_n,
    rtcc_sync_if.eng    sif
);

    // ****************************************
    // Stand-in for the counter-domain round trip
    // ****************************************
    typedef struct packed {
        logic [7:0] cnt;
        logic       busy;
        logic       done;
    } rtcc_sync_st_t;

    rtcc_sync_st_t st_ff;
    rtcc_sync_st_t nxt_st;

    always_comb begin
        nxt_st      = st_ff;
        nxt_st.done = 1'b0;
        if (sif.req) begin
            // A new request restarts the wait
            nxt_st.cnt = 8'(SYNC_LEN);
        end else if (st_ff.cnt == 8'h01) begin
            nxt_st.cnt  = 8'h00;
            nxt_st.done = 1'b1;
        end else if (st_ff.cnt != 8'h00) begin
            nxt_st.cnt = st_ff.cnt - 8'h01;
        end
        // Busy still high in the done cycle so it drops with the caller's state
        nxt_st.busy = (nxt_st.cnt != 8'h00) || nxt_st.done;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sif.busy = st_ff.busy;
    assign sif.done = st_ff.done;

endmodule
`default_nettype wire

// ==== rtcc_sync_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface rtcc_sync_if;
    logic req;
    logic busy;
    logic done;

    modport ctl (output req, input busy, input done);
    modport eng (input req, output busy, output done);
endinterface
`default_nettype wire
